/* File: src/spwm_channel.sv */
// Standard PWM channel with three shared timers
module spwm_channel
  import spwm_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic resetn, // Sync reset, active low
  input wire logic pwmMode, // Channel in PWM mode
  input wire logic [1:0] timerChoice, // timer_choice_field
  input wire logic [7:0] dutyHighBits, // duty_high_bits_reg
  input wire logic [7:0] channelControl, // channel_control_reg
  input wire logic shadowWrEn, // Software write to shadow
  input wire logic [7:0] shadowWrData, // Shadow write data
  input wire logic [2:0] timerOn, // timer_on_bit per timer
  input wire logic [5:0] prescale, // prescale_field per timer, 2 bits each
  input wire logic [23:0] periodLimit, // period_limit_reg per timer, 8 bits each
  input wire logic [2:0] flagClear, // Clear timer_match_flag per timer
  output logic [7:0] dutyShadow, // duty_shadow_reg readback
  output logic [2:0] timerMatchFlag, // timer_match_flag per timer
  output logic [23:0] periodTimer, // period_timer values
  output logic pwmOut // pwm_output_pin
);
  logic [9:0] latch_q;
  logic [9:0] progDuty;
  logic pin_q;
  logic [2:0] flag_q;
  logic [2:0] incr;
  logic [2:0] match;
  logic [1:0] lows [TIMER_COUNT];
  logic [7:0] counts [TIMER_COUNT];
  logic selIncr;
  logic selMatch;
  logic [9:0] timeBase;
  logic rollover;
  logic roll_q;
  logic [1:0] selIdx;
  logic [1:0] selPre;
  logic [7:0] selLimit;
  logic selOn;
  logic [12:0] cfgNow;
  logic [12:0] cfg_q;
  logic [16:0] perExp;
  logic [16:0] perCnt_q;
  logic perValid_q;

  // Three shared timers
  for (genvar i = 0; i < TIMER_COUNT; i++)
  begin : g_tmr
    spwm_tick_if tick ();
    spwm_timer u_tmr (
      .clk(clk),
      .resetn(resetn),
      .timerOn(timerOn[i]),
      .prescale(prescale[2*i +: 2]),
      .periodLimit(periodLimit[8*i +: 8]),
      .tick(tick.timer)
    );
    assign incr[i] = tick.incr;
    assign match[i] = tick.match;
    assign lows[i] = tick.low;
    assign counts[i] = tick.count;
    assign periodTimer[8*i +: 8] = tick.count;
  end

  // Selected timer; unused code falls back to the first
  always_comb
  begin
    if (timerChoice == 2'h1)
    begin
      selIncr = incr[1];
      selMatch = match[1];
      timeBase = {counts[1], lows[1]};
    end
    else if (timerChoice == 2'h2)
    begin
      selIncr = incr[2];
      selMatch = match[2];
      timeBase = {counts[2], lows[2]};
    end
    else
    begin
      selIncr = incr[0];
      selMatch = match[0];
      timeBase = {counts[0], lows[0]};
    end
  end // R1 R13

  assign progDuty = {dutyHighBits, channelControl[DUTY_LSB_HI:DUTY_LSB_LO]}; // R7
  assign rollover = selIncr && selMatch; // R2 R3

  // Rollover seen one clock late; the pin sets from it so that both pin edges
  // carry the same register delay and the high time comes out exact
  always_ff @(posedge clk)
  begin
    if (!resetn)
      roll_q <= 1'b0;
    else
      roll_q <= rollover; // R4
  end

  // Setup of the selected timer, used only by the period check
  always_comb
  begin
    if (timerChoice == 2'h3)
      selIdx = 2'h0;
    else
      selIdx = timerChoice;
    selPre = prescale[2*selIdx +: 2];
    selLimit = periodLimit[8*selIdx +: 8];
    selOn = timerOn[selIdx];
    perExp = (17'(selLimit) + 17'h00001) << ({1'b0, selPre, 1'b0} + 4'h2);
  end
  assign cfgNow = {timerChoice, selPre, selLimit, selOn};

  // Clocks since the last rollover; saturates so a stopped timer cannot wrap it
  always_ff @(posedge clk)
  begin
    if (!resetn || rollover)
      perCnt_q <= 17'h00001;
    else if (perCnt_q != 17'h1FFFF)
      perCnt_q <= perCnt_q + 17'h00001;
  end

  // Any setup change voids the period under way; first period after it is not judged
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cfg_q <= '0;
      perValid_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfgNow;
      if (cfgNow != cfg_q)
        perValid_q <= 1'b0;
      else if (rollover)
        perValid_q <= 1'b1;
    end
  end

  // Whole periods last (limit + 1) x 4 x prescale clocks; postscale plays no part
  period_len_a: assert property (@(posedge clk) disable iff (!resetn) // R2
    rollover && perValid_q |-> perCnt_q == perExp)
    else $error("period length wrong");

  // Match flags; set wins over clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
      flag_q <= '0;
    else
      flag_q <= (flag_q & ~flagClear) | (incr & match);
  end

  // Flags follow every rollover, even one that meets a clear
  flag_set0_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    incr[0] && match[0] |=> timerMatchFlag[0])
    else $error("flag 0 not set at rollover");
  flag_set1_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    incr[1] && match[1] |=> timerMatchFlag[1])
    else $error("flag 1 not set at rollover");
  flag_set2_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    incr[2] && match[2] |=> timerMatchFlag[2])
    else $error("flag 2 not set at rollover");
  flag_clear_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    flagClear[0] && !(incr[0] && match[0]) |=> !timerMatchFlag[0])
    else $error("flag 0 not cleared");

  // Double buffer: in PWM mode latch only at rollover so mid-period writes cannot glitch
  always_ff @(posedge clk)
  begin
    if (!resetn)
      latch_q <= DUTY_RESET;
    else if (pwmMode && rollover)
      latch_q <= progDuty; // R5 R8 R12
    else if (!pwmMode && shadowWrEn)
      latch_q <= {shadowWrData, latch_q[1:0]}; // R9
  end

  // Pin: set a clock after rollover, cleared at duty match; duty beyond period stays high
  always_ff @(posedge clk)
  begin
    if (!resetn || !pwmMode)
      pin_q <= 1'b0;
    else if (roll_q)
      pin_q <= (latch_q != DUTY_RESET); // R4
    else if (timeBase == latch_q)
      pin_q <= 1'b0; // R14 R10 R11
  end

  assign dutyShadow = latch_q[9:2];
  assign timerMatchFlag = flag_q;
  assign pwmOut = pin_q;

  // Pin is high two clocks after every rollover when duty is nonzero
  rollover_high_a: assert property (@(posedge clk) disable iff (!resetn) // R4
    pwmMode && rollover && progDuty != DUTY_RESET ##1 pwmMode |=> pwmOut)
    else $error("pin not set at rollover");
  zero_duty_a: assert property (@(posedge clk) disable iff (!resetn) // R4
    pwmMode && rollover && progDuty == DUTY_RESET |=> ##1 !pwmOut)
    else $error("pin set with zero duty");
  shadow_load_a: assert property (@(posedge clk) disable iff (!resetn) // R5
    pwmMode && rollover |=> latch_q == $past(progDuty))
    else $error("shadow not loaded");
  shadow_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R9
    pwmMode && $past(pwmMode) && !$past(rollover) |-> $stable(latch_q))
    else $error("shadow changed mid period");
  duty_clear_a: assert property (@(posedge clk) disable iff (!resetn) // R14
    pwmMode && !roll_q && timeBase == latch_q |=> !pwmOut)
    else $error("pin not cleared at duty match");
  pin_off_a: assert property (@(posedge clk) disable iff (!resetn) // R4
    !pwmMode |=> !pwmOut)
    else $error("pin high outside pwm mode");
  // Between set and clear events the pin must not move
  pin_glitch_a: assert property (@(posedge clk) disable iff (!resetn) // R12
    $past(resetn) && $past(pwmMode) && !$past(roll_q)
      && $past(timeBase) != $past(latch_q) |-> $stable(pwmOut))
    else $error("pin glitched mid period");
  timer_wrap_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    incr[0] && match[0] |=> counts[0] == TIMER_RESET)
    else $error("timer did not wrap");
  timer_step_a: assert property (@(posedge clk) disable iff (!resetn) // R17
    incr[0] && !match[0] |=> counts[0] == $past(counts[0]) + 8'h01)
    else $error("timer did not step");
  timer_idle_a: assert property (@(posedge clk) disable iff (!resetn) // R17
    !timerOn[0] |=> $stable(counts[0]))
    else $error("stopped timer moved");
  // The other two timers follow the same counting rules
  timer1_wrap_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    incr[1] && match[1] |=> counts[1] == TIMER_RESET)
    else $error("timer 1 did not wrap");
  timer1_step_a: assert property (@(posedge clk) disable iff (!resetn) // R17
    incr[1] && !match[1] |=> counts[1] == $past(counts[1]) + 8'h01)
    else $error("timer 1 did not step");
  timer1_idle_a: assert property (@(posedge clk) disable iff (!resetn) // R17
    !timerOn[1] |=> $stable(counts[1]))
    else $error("stopped timer 1 moved");
  timer2_wrap_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    incr[2] && match[2] |=> counts[2] == TIMER_RESET)
    else $error("timer 2 did not wrap");
  timer2_step_a: assert property (@(posedge clk) disable iff (!resetn) // R17
    incr[2] && !match[2] |=> counts[2] == $past(counts[2]) + 8'h01)
    else $error("timer 2 did not step");
  timer2_idle_a: assert property (@(posedge clk) disable iff (!resetn) // R17
    !timerOn[2] |=> $stable(counts[2]))
    else $error("stopped timer 2 moved");
endmodule : spwm_channel

/* File: src/spwm_pkg.sv */
// Summary of operation
// R1 - Period time base comes from one of three shared 8-bit timers via select field.
// R2 - Period equals (period limit + 1) times four oscillator periods times prescale.
// R3 - Period timer clears on the increment after it equals the period limit.
// R4 - Rollover sets the output pin high unless duty value is zero.
// R5 - Rollover copies programmed duty into shadow register and two-bit latch.
// R6 - Postscaler never affects period; only prescaler and period limit do.
// R7 - Duty is ten bits: eight high bits in one register, two LSBs in control bits 5:4.
// R8 - Duty writes accepted anytime but take effect only after the current period.
// R9 - In PWM mode the shadow register is readable but ignores software writes.
// R10 - High time equals duty value times oscillator period times prescale.
// R11 - Duty ratio is duty over 4(period+1); larger values hold output high.
// R12 - Duty is double buffered so the output never glitches on update.
// R13 - Time base is timer plus two low bits: clock phase or prescaler bits.
// R14 - Output goes low when ten-bit time base equals the buffered duty value.
// R15 - Software sequence: disable driver, configure, start timer, await flag, enable driver.
// R16 - Software may skip the flag wait if a truncated first period is acceptable.
// R17 - Selected timer counts up by one per prescaled tick while on, else holds.
package spwm_pkg;
  localparam int TIMER_COUNT = 3;
  localparam int TIMER_WIDTH = 8;
  localparam int DUTY_WIDTH = 10;
  localparam int PRE_WIDTH = 6;
  localparam int DUTY_LSB_HI = 5;
  localparam int DUTY_LSB_LO = 4;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [1:0] PRESCALE_1 = 2'h0;
  localparam logic [1:0] PRESCALE_4 = 2'h1;
  localparam logic [1:0] PRESCALE_16 = 2'h2;
  localparam logic [1:0] PRESCALE_64 = 2'h3;
  localparam logic [5:0] PRE_MAX_1 = 6'h00;
  localparam logic [5:0] PRE_MAX_4 = 6'h03;
  localparam logic [5:0] PRE_MAX_16 = 6'h0F;
  localparam logic [5:0] PRE_MAX_64 = 6'h3F;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [9:0] DUTY_RESET = 10'h000;
endpackage : spwm_pkg

/* File: src/spwm_tick_if.sv */
// Prescaled tick bundle from one shared timer to the channel
interface spwm_tick_if;
  import spwm_pkg::*;
  logic incr;
  logic [7:0] count;
  logic [1:0] low;
  logic match;
  modport timer (output incr, output count, output low, output match);
  modport chan (input incr, input count, input low, input match);
endinterface : spwm_tick_if

/* File: src/spwm_timer.sv */
// One shared 8-bit period timer with prescaler
module spwm_timer
  import spwm_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic resetn, // Sync reset, active low
  input wire logic timerOn, // timer_on_bit
  input wire logic [1:0] prescale, // prescale_field
  input wire logic [7:0] periodLimit, // period_limit_reg
  spwm_tick_if.timer tick // Tick bundle out
);
  logic [5:0] pre_q;
  logic [7:0] cnt_q;
  logic [5:0] preMax;
  logic [1:0] ph_q;
  logic phaseEnd;

  // Ratio decode; postscaler deliberately absent
  always_comb
  begin
    case (prescale)
      PRESCALE_1: preMax = PRE_MAX_1;
      PRESCALE_4: preMax = PRE_MAX_4;
      PRESCALE_16: preMax = PRE_MAX_16;
      default: preMax = PRE_MAX_64;
    endcase
  end // R6

  // Prescaler; each clk is one oscillator period (phase counts quarter-cycles)
  always_ff @(posedge clk)
  begin
    if (!resetn || !timerOn)
      pre_q <= '0;
    else if (pre_q >= preMax)
      pre_q <= '0;
    else
      pre_q <= pre_q + 6'h01;
  end

  // Increment on the tick that ends four oscillator periods of prescale
  assign tick.incr = timerOn && (pre_q >= preMax) && (pre_q[1:0] == PHASE_LAST
    || preMax == PRE_MAX_1) && phaseEnd; // R17
  // Phase of instruction cycle for 1:1
  always_ff @(posedge clk)
  begin
    if (!resetn || !timerOn)
      ph_q <= '0;
    else if (preMax == PRE_MAX_1 || pre_q >= preMax)
      ph_q <= ph_q + 2'h1;
  end
  assign phaseEnd = (ph_q == PHASE_LAST);

  // Timer counter with match rollover
  always_ff @(posedge clk)
  begin
    if (!resetn)
      cnt_q <= TIMER_RESET;
    else if (tick.incr)
      cnt_q <= tick.match ? TIMER_RESET : cnt_q + 8'h01; // R3
  end

  assign tick.count = cnt_q;
  assign tick.match = (cnt_q == periodLimit);
  // Low two bits of the time base
  assign tick.low = ph_q; // R13
endmodule : spwm_timer

/* File: verif/spwm_load.sv */
// Resistive load on the output pin, tallying high cycles and rising edges
module spwm_load
(
  input wire logic clk, // System clock
  input wire logic pin, // Observed pwm_output_pin
  input wire logic clr, // Restart the tally
  output logic [15:0] highCnt, // Cycles seen high
  output logic [15:0] riseCnt // Rising edges seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pinQ;

  // Tally over whole periods, so the start phase does not matter
  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      highCnt <= 16'h0000;
      riseCnt <= 16'h0000;
    end
    else
    begin
      if (pin)
        highCnt <= highCnt + 16'h0001;
      if (pin && !pinQ)
        riseCnt <= riseCnt + 16'h0001;
    end
    pinQ <= pin;
  end
endmodule : spwm_load

/* File: verif/spwm_channel_tb.sv */
// Self-checking bench for the PWM channel
module spwm_channel_tb
  import spwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, resetn = 1'b0, pwmMode = 1'b0, shadowWrEn = 1'b0, loadClr = 1'b1;
  logic [1:0] timerChoice = 2'h0;
  logic [7:0] dutyHighBits = 8'h00, channelControl = 8'h00, shadowWrData = 8'h00;
  logic [2:0] timerOn = 3'h0, flagClear = 3'h0, timerMatchFlag;
  logic [5:0] prescale = 6'h00;
  logic [23:0] periodLimit = 24'h000000, periodTimer;
  logic [7:0] dutyShadow;
  logic pwmOut;
  logic [15:0] highCnt, riseCnt;
  int nFail = 0, checked = 0;

  spwm_channel dut_u (.clk(clk), .resetn(resetn), .pwmMode(pwmMode),
    .timerChoice(timerChoice), .dutyHighBits(dutyHighBits), .channelControl(channelControl),
    .shadowWrEn(shadowWrEn), .shadowWrData(shadowWrData), .timerOn(timerOn),
    .prescale(prescale), .periodLimit(periodLimit), .flagClear(flagClear),
    .dutyShadow(dutyShadow), .timerMatchFlag(timerMatchFlag), .periodTimer(periodTimer),
    .pwmOut(pwmOut));
  spwm_load load_u (.clk(clk), .pin(pwmOut), .clr(loadClr), .highCnt(highCnt),
    .riseCnt(riseCnt));

  always #50 clk = ~clk;

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      nFail++;
    end
  endtask : check

  task end_sim;
    $display("checks=%0d fails=%0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // Clear the match flag, then wait for the next rollover
  task syncRoll(input int t);
    int i;
    flagClear[t] = 1'b1;
    @(negedge clk);
    flagClear = 3'h0;
    for (i = 0; i < 5000 && timerMatchFlag[t] !== 1'b1; i++)
      @(negedge clk);
    if (i == 5000)
    begin
      nFail++;
      end_sim();
    end
  endtask : syncRoll

  // Configure in software order, then tally two settled periods
  task runPwm(input int t, input logic [1:0] ps, input logic [7:0] lim, input logic [9:0] d);
    int pre, per, hi;
    pre = 1 << (2 * ps);
    per = (lim + 1) * 4 * pre;
    hi = (d * pre < per) ? d * pre : per;
    periodLimit[t*8+:8] = lim;
    pwmMode = 1'b1;
    dutyHighBits = d[9:2];
    channelControl = {2'h0, d[1:0], 4'h0};
    timerChoice = 2'(t);
    prescale[t*2+:2] = ps;
    timerOn[t] = 1'b1;
    syncRoll(t);
    repeat (per) @(negedge clk);
    loadClr = 1'b1;
    @(negedge clk);
    loadClr = 1'b0;
    repeat (2 * per) @(negedge clk);
    check(highCnt, 16'(2 * hi));
    check(riseCnt, (d == 10'h000 || hi == per) ? 16'h0000 : 16'h0002);
    check(16'(dutyShadow), 16'(d[9:2]));
    $display("run timer=%0d pre=%0d lim=%0d duty=%0d done", t, pre, lim, d);
  endtask : runPwm

  // Duty writes and shadow writes land mid-period
  task dutyHold;
    syncRoll(0);
    check(16'(periodTimer[7:0]), 16'h0000);
    dutyHighBits = 8'h02;
    shadowWrData = 8'hA5;
    shadowWrEn = 1'b1;
    @(negedge clk);
    shadowWrEn = 1'b0;
    @(negedge clk);
    check(16'(dutyShadow), 16'h0004);
    syncRoll(0);
    check(16'(dutyShadow), 16'h0002);
    pwmMode = 1'b0;
    shadowWrEn = 1'b1;
    @(negedge clk);
    shadowWrEn = 1'b0;
    check(16'(dutyShadow), 16'h00A5);
    check(16'(pwmOut), 16'h0000);
    $display("duty hold done");
  endtask : dutyHold

  initial
  begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    check(16'(pwmOut), 16'h0000);
    runPwm(0, 2'h0, 8'h03, 10'h00A);
    runPwm(1, 2'h1, 8'h02, 10'h005);
    runPwm(2, 2'h2, 8'h01, 10'h003);
    runPwm(1, 2'h3, 8'h02, 10'h007);
    runPwm(0, 2'h0, 8'h03, 10'h000);
    runPwm(0, 2'h0, 8'h03, 10'h010);
    runPwm(0, 2'h0, 8'h03, 10'h3FF);
    runPwm(0, 2'h0, 8'h03, 10'h012);
    dutyHold();
    end_sim();
  end
endmodule : spwm_channel_tb
